// [core/csx_defs.svh]
// constants for the coast stop and external trip block
// What this block does
// - coast stop asserted: output drive off, motor coasts freely
// - coast stop released: drive resumes only if run command still asserted
// - restart mode picks zero frequency or present motor speed after release
// - programmable restart wait after release; zero means no wait
// - coast stop released: normal output, stop request turns drive enable off at once
// - any of eight terminals takes coast stop by code 11, trip by 12
// - external trip input puts device in trip, error code 12, output stopped
// - only an off-to-on transition of the trip input latches a trip
// - releasing the trip input does not clear the trip
// - trip cleared by reset or power cycle; power cycle returns device to stop
// - on trip the motor coasts and the alarm rises at once
// - reset during trip clears alarm and error indication
// - reset released with run still asserted: drive resumes without new run
// - on-to-off trip input makes no event; recorded events stay until reset
// - with restart guard on, no automatic restart after a cleared trip
`ifndef CSX_DEFS_SVH
`define CSX_DEFS_SVH

`define CSX_NTERM 8
`define CSX_FUNC_W 8
`define CSX_OPT_COAST 8'h0b
`define CSX_OPT_TRIP 8'h0c
`define CSX_ERR_NONE 8'h00
`define CSX_ERR_EXT 8'h0c

`define CSX_ADDR_FUNC_LO 8'h00
`define CSX_ADDR_FUNC_HI 8'h04
`define CSX_ADDR_RESTART 8'h08
`define CSX_ADDR_STATUS 8'h0c
`define CSX_ADDR_HISTORY 8'h10

`define CSX_FUNC_RST 32'h0000_0000
`define CSX_RESTART_RST 32'h0000_0000
`define CSX_MODE_BIT 0
`define CSX_GUARD_BIT 1
`define CSX_WAIT_LSB 8
`define CSX_WAIT_MSB 23
`define CSX_WAIT_W 16
`define CSX_KP_RESET_BIT 0
`define CSX_ST_TRIP_BIT 0
`define CSX_ST_ALARM_BIT 1
`define CSX_ST_GUARD_BIT 2
`define CSX_ST_ERR_LSB 8
`define CSX_ST_ERR_MSB 15
`define CSX_ST_STATE_LSB 16
`define CSX_ST_STATE_MSB 20
`define CSX_HIST_W 8

`define CSX_CLK_NS 10
`define CSX_TICK_NS 1000
`define CSX_TICK_CYC (`CSX_TICK_NS / `CSX_CLK_NS)

`endif

// [core/csx_pkg.sv]
// types for the coast stop and external trip block
package csx_pkg;

   typedef enum logic [4:0]
   {
      CSX_ST_STOP = 5'b00001,
      CSX_ST_RUN = 5'b00010,
      CSX_ST_COAST = 5'b00100,
      CSX_ST_WAIT = 5'b01000,
      CSX_ST_TRIP = 5'b10000
   } csx_state_t;

endpackage

// [core/csx_term_sync.sv]
// two-flop synchroniser with rising edge detect for terminal inputs
`timescale 1ns/100ps
`default_nettype none
module csx_term_sync
#(
   parameter int W = 8
)
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_pin,
   output logic [W-1:0] o_level,
   output logic [W-1:0] o_rise
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] last_reg;

   // first stage feeds only the second stage
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
         last_reg <= '0;
      end
      else
      begin
         meta_reg <= i_pin;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // level and one-cycle off-to-on pulse
   assign o_level = sync_reg;
   assign o_rise = sync_reg & ~last_reg;

endmodule
`default_nettype wire

// [core/csx_coast_trip.sv]
// coast stop and latched external trip control with register port
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "csx_defs.svh"
module csx_coast_trip
#(
   parameter int NTERM = `CSX_NTERM,
   parameter int TICK_CYC = `CSX_TICK_CYC,
   parameter int FW = 16
)
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [NTERM-1:0] i_term,
   input wire logic i_run_cmd,
   input wire logic i_reset_terminal_input,
   input wire logic [FW-1:0] i_motor_freq,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_drive_en,
   output logic o_start_load,
   output logic [FW-1:0] o_start_freq,
   output logic o_alarm,
   output logic [7:0] o_error_code
);

   localparam int SW = NTERM + 2;

   logic [SW-1:0] sync_lvl;
   logic [SW-1:0] sync_rise;
   logic [NTERM-1:0] coast_hit;
   logic [NTERM-1:0] trip_hit;
   logic [31:0] func_lo_reg;
   logic [31:0] func_hi_reg;
   logic [31:0] restart_reg;
   logic trip_reg;
   logic trip_next;
   logic guard_blk_reg;
   logic guard_blk_next;
   logic [`CSX_HIST_W-1:0] hist_reg;
   logic [`CSX_WAIT_W-1:0] wait_cnt_reg;
   logic [`CSX_WAIT_W-1:0] wait_cnt_next;
   logic [$clog2(TICK_CYC+1)-1:0] tick_cnt_reg;
   csx_pkg::csx_state_t state_reg;
   csx_pkg::csx_state_t state_next;
   logic start_next;
   logic [FW-1:0] start_freq_next;

   // terminals, run command and reset terminal share one synchroniser
   csx_term_sync #(.W(SW)) u_sync
   (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_pin({i_reset_terminal_input, i_run_cmd, i_term}),
      .o_level(sync_lvl),
      .o_rise(sync_rise)
   );

   wire run_lvl = sync_lvl[NTERM];
   wire run_rise = sync_rise[NTERM];
   wire rst_lvl = sync_lvl[NTERM+1];
   wire rst_rise = sync_rise[NTERM+1];

   // per-terminal function decode
   genvar g;
   generate
      for (g = 0; g < NTERM; g++)
      begin : g_term
         wire [`CSX_FUNC_W-1:0] func_sel;
         if (g < 4)
         begin : g_lo
            assign func_sel = func_lo_reg[g*`CSX_FUNC_W +: `CSX_FUNC_W];
         end
         else
         begin : g_hi
            assign func_sel = func_hi_reg[(g-4)*`CSX_FUNC_W +: `CSX_FUNC_W];
         end
         assign coast_hit[g] = sync_lvl[g] && (func_sel == `CSX_OPT_COAST);
         assign trip_hit[g] = sync_rise[g] && (func_sel == `CSX_OPT_TRIP);
      end
   endgenerate

   // register port decode
   wire wr_func_lo = i_wr && (i_addr == `CSX_ADDR_FUNC_LO);
   wire wr_func_hi = i_wr && (i_addr == `CSX_ADDR_FUNC_HI);
   wire wr_restart = i_wr && (i_addr == `CSX_ADDR_RESTART);
   wire kp_reset = i_wr && (i_addr == `CSX_ADDR_STATUS) && i_wdata[`CSX_KP_RESET_BIT];
   wire mode_speed = restart_reg[`CSX_MODE_BIT];
   wire guard_en = restart_reg[`CSX_GUARD_BIT];
   wire [`CSX_WAIT_W-1:0] wait_time = restart_reg[`CSX_WAIT_MSB:`CSX_WAIT_LSB];

   // combined events
   wire coast_lvl = |coast_hit;
   wire trip_set = |trip_hit;
   wire reset_req = rst_lvl || kp_reset;
   wire reset_pulse = rst_rise || kp_reset;
   wire tick = (tick_cnt_reg == ($clog2(TICK_CYC+1))'(TICK_CYC - 1));
   wire wait_done = tick && (wait_cnt_reg == `CSX_WAIT_W'(1));
   wire [FW-1:0] resume_freq = mode_speed ? i_motor_freq : '0;

   // status and read mux
   wire [31:0] status_word = {11'h000, state_reg, o_error_code,
                              5'h00, guard_blk_reg, o_alarm, trip_reg};
   wire [31:0] rd_mux =
      (i_addr == `CSX_ADDR_FUNC_LO) ? func_lo_reg :
      (i_addr == `CSX_ADDR_FUNC_HI) ? func_hi_reg :
      (i_addr == `CSX_ADDR_RESTART) ? restart_reg :
      (i_addr == `CSX_ADDR_STATUS) ? status_word :
      (i_addr == `CSX_ADDR_HISTORY) ? {{(32-`CSX_HIST_W){1'b0}}, hist_reg} :
      32'h0000_0000;

   // trip latch: a new edge wins over a clear
   assign trip_next = trip_set || (trip_reg && !reset_req);

   // restart guard block
   always_comb
   begin
      guard_blk_next = guard_blk_reg;
      if (trip_set && guard_en)
         guard_blk_next = 1'b1;
      else if (run_rise || (reset_pulse && !trip_reg))
         guard_blk_next = 1'b0;
   end

   // control state machine
   always_comb
   begin
      state_next = state_reg;
      start_next = 1'b0;
      start_freq_next = o_start_freq;
      wait_cnt_next = wait_cnt_reg;
      case (state_reg)
         csx_pkg::CSX_ST_STOP:
         begin
            if (trip_set)
               state_next = csx_pkg::CSX_ST_TRIP;
            else if (run_lvl && !coast_lvl && !guard_blk_reg && !trip_reg)
            begin
               state_next = csx_pkg::CSX_ST_RUN;
               start_next = 1'b1;
               start_freq_next = '0;
            end
         end
         csx_pkg::CSX_ST_RUN:
         begin
            if (trip_set)
               state_next = csx_pkg::CSX_ST_TRIP;
            else if (coast_lvl)
               state_next = csx_pkg::CSX_ST_COAST;
            else if (!run_lvl)
               state_next = csx_pkg::CSX_ST_STOP;
         end
         csx_pkg::CSX_ST_COAST:
         begin
            if (trip_set)
               state_next = csx_pkg::CSX_ST_TRIP;
            else if (!coast_lvl && !run_lvl)
               state_next = csx_pkg::CSX_ST_STOP;
            else if (!coast_lvl && (wait_time == '0))
            begin
               state_next = csx_pkg::CSX_ST_RUN;
               start_next = 1'b1;
               start_freq_next = resume_freq;
            end
            else if (!coast_lvl)
            begin
               state_next = csx_pkg::CSX_ST_WAIT;
               wait_cnt_next = wait_time;
            end
         end
         csx_pkg::CSX_ST_WAIT:
         begin
            if (trip_set)
               state_next = csx_pkg::CSX_ST_TRIP;
            else if (coast_lvl)
               state_next = csx_pkg::CSX_ST_COAST;
            else if (!run_lvl)
               state_next = csx_pkg::CSX_ST_STOP;
            else if (wait_done)
            begin
               state_next = csx_pkg::CSX_ST_RUN;
               start_next = 1'b1;
               start_freq_next = resume_freq;
            end
            else if (tick)
               wait_cnt_next = wait_cnt_reg - `CSX_WAIT_W'(1);
         end
         csx_pkg::CSX_ST_TRIP:
         begin
            if (!trip_reg && !trip_set && !rst_lvl)
            begin
               if (run_lvl && !coast_lvl && !guard_blk_next)
               begin
                  state_next = csx_pkg::CSX_ST_RUN;
                  start_next = 1'b1;
                  start_freq_next = '0;
               end
               else
                  state_next = csx_pkg::CSX_ST_STOP;
            end
         end
         default:
            state_next = csx_pkg::CSX_ST_STOP;
      endcase
   end

   // configuration registers
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         func_lo_reg <= `CSX_FUNC_RST;
         func_hi_reg <= `CSX_FUNC_RST;
         restart_reg <= `CSX_RESTART_RST;
      end
      else
      begin
         if (wr_func_lo)
            func_lo_reg <= i_wdata;
         if (wr_func_hi)
            func_hi_reg <= i_wdata;
         if (wr_restart)
            restart_reg <= i_wdata & 32'h00ff_ff03;
      end
   end

   // trip, history and wait timing state
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         trip_reg <= 1'b0;
         guard_blk_reg <= 1'b0;
         hist_reg <= '0;
         wait_cnt_reg <= '0;
         tick_cnt_reg <= '0;
         state_reg <= csx_pkg::CSX_ST_STOP;
      end
      else
      begin
         trip_reg <= trip_next;
         guard_blk_reg <= guard_blk_next;
         if (trip_set && (hist_reg != '1))
            hist_reg <= hist_reg + `CSX_HIST_W'(1);
         else if (reset_req && !trip_set)
            hist_reg <= '0;
         wait_cnt_reg <= wait_cnt_next;
         tick_cnt_reg <= (tick || (state_reg != csx_pkg::CSX_ST_WAIT)) ? '0 :
                         tick_cnt_reg + 1'b1;
         state_reg <= state_next;
      end
   end

   // registered outputs
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_drive_en <= 1'b0;
         o_start_load <= 1'b0;
         o_start_freq <= '0;
         o_alarm <= 1'b0;
         o_error_code <= `CSX_ERR_NONE;
         o_rdata <= 32'h0000_0000;
      end
      else
      begin
         o_drive_en <= (state_next == csx_pkg::CSX_ST_RUN);
         o_start_load <= start_next;
         o_start_freq <= start_freq_next;
         o_alarm <= trip_next;
         o_error_code <= trip_next ? `CSX_ERR_EXT : `CSX_ERR_NONE;
         o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   sequence s_coast_release;
      state_reg == csx_pkg::CSX_ST_COAST && !coast_lvl && !trip_set;
   endsequence

   sequence s_trip_cleared;
      state_reg == csx_pkg::CSX_ST_TRIP && !trip_reg && !trip_set && !rst_lvl;
   endsequence

   property p_coast_off;
      coast_lvl && !trip_set |=> !o_drive_en;
   endproperty
   a_coast_off: assert property (p_coast_off) else $error("drive on in coast stop");

   property p_release_run;
      s_coast_release ##0 (run_lvl && wait_time == '0) |=> o_drive_en && o_start_load;
   endproperty
   a_release_run: assert property (p_release_run) else $error("no resume after release");

   property p_release_norun;
      s_coast_release ##0 !run_lvl |=> !o_drive_en && !o_start_load;
   endproperty
   a_release_norun: assert property (p_release_norun) else $error("resumed without run");

   property p_mode_zero;
      o_start_load && !$past(mode_speed) |-> o_start_freq == '0;
   endproperty
   a_mode_zero: assert property (p_mode_zero) else $error("restart not from zero");

   property p_wait;
      s_coast_release ##0 (run_lvl && wait_time != '0) |=>
         state_reg == csx_pkg::CSX_ST_WAIT && !o_drive_en;
   endproperty
   a_wait: assert property (p_wait) else $error("restart wait skipped");

   property p_trip;
      trip_set |=> o_alarm && o_error_code == `CSX_ERR_EXT && !o_drive_en;
   endproperty
   a_trip: assert property (p_trip) else $error("trip not reported at once");

   property p_single_event;
      trip_set |=> !trip_set;
   endproperty
   a_single_event: assert property (p_single_event) else $error("double trip event");

   property p_hold;
      trip_reg && !reset_req |=> trip_reg && o_alarm;
   endproperty
   a_hold: assert property (p_hold) else $error("trip cleared without reset");

   property p_clear;
      trip_reg && reset_req && !trip_set |=> !o_alarm && o_error_code == `CSX_ERR_NONE;
   endproperty
   a_clear: assert property (p_clear) else $error("reset did not clear alarm");

   property p_resume;
      s_trip_cleared ##0 (run_lvl && !coast_lvl && !guard_blk_next) |=> o_drive_en;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume after trip reset");

   property p_guard;
      s_trip_cleared ##0 guard_blk_next |=> state_reg == csx_pkg::CSX_ST_STOP && !o_drive_en;
   endproperty
   a_guard: assert property (p_guard) else $error("restart guard ignored");

   property p_history;
      !reset_req && !trip_set |=> $stable(hist_reg);
   endproperty
   a_history: assert property (p_history) else $error("trip history changed");

endmodule
`default_nettype wire

// [sim/csx_contacts.sv]
// far-side model: terminal contacts, run command, reset terminal, motor speed
`timescale 1ns/100ps
`default_nettype none
module csx_contacts
(
   input wire logic i_mclk,
   output logic [7:0] o_term,
   output logic o_run_cmd,
   output logic o_reset_terminal_input,
   output logic [15:0] o_motor_freq
);
   // contacts open and motor at rest at power-up
   initial
   begin
      o_term = 8'h00;
      o_run_cmd = 1'b0;
      o_reset_terminal_input = 1'b0;
      o_motor_freq = 16'h0000;
   end

   // each change lands just after a rising edge, then holds
   task automatic set_pin(input int n, input logic v);
      @(posedge i_mclk);
      o_term[n] <= v;
   endtask

   // run level; a fresh rising edge also lifts a restart block
   task automatic set_run(input logic v);
      @(posedge i_mclk);
      o_run_cmd <= v;
   endtask

   // reset terminal clears a latched trip while high
   task automatic set_rst(input logic v);
      @(posedge i_mclk);
      o_reset_terminal_input <= v;
   endtask

   // unassigned terminals chatter at random; keep marks the assigned ones
   task automatic set_spare(input logic [7:0] keep, input logic [7:0] v);
      @(posedge i_mclk);
      o_term <= (o_term & keep) | (v & ~keep);
   endtask

   // motor speed seen by the drive, steady between changes
   task automatic set_speed(input logic [15:0] f);
      @(posedge i_mclk);
      o_motor_freq <= f;
   endtask
endmodule
`default_nettype wire

// [sim/csx_coast_trip_tb.sv]
// self-checking bench for coast stop and external trip control
`timescale 1ns/100ps
`default_nettype none
`include "csx_defs.svh"
module csx_coast_trip_tb;
   localparam int TICK = 2;
   logic i_mclk;
   logic i_rst;
   logic [7:0] i_addr;
   logic [31:0] i_wdata;
   logic i_wr;
   logic i_rd;
   wire logic [7:0] term;
   wire logic run;
   wire logic rst_term;
   wire logic [15:0] speed;
   logic [31:0] rdata;
   logic drive_en;
   logic start_load;
   logic [15:0] start_freq;
   logic alarm;
   logic [7:0] error_code;
   logic [31:0] rd_q[$];
   logic [15:0] st_q[$];
   logic rd_d;
   logic [31:0] rnd;
   logic [31:0] exp_f;
   logic [63:0] fmap;
   logic [15:0] spd;
   logic [7:0] keep_m;
   int bad_count;
   int checks_done;
   int c;
   int t;
   int w;

   // 100 MHz clock
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   csx_coast_trip #(.TICK_CYC(TICK)) i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_term(term),
      .i_run_cmd(run), .i_reset_terminal_input(rst_term), .i_motor_freq(speed),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
      .o_drive_en(drive_en), .o_start_load(start_load), .o_start_freq(start_freq),
      .o_alarm(alarm), .o_error_code(error_code));

   csx_contacts i_far (.i_mclk(i_mclk), .o_term(term), .o_run_cmd(run),
      .o_reset_terminal_input(rst_term), .o_motor_freq(speed));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   function automatic logic [31:0] xs();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction

   // status word: trip implies alarm and error code
   function automatic logic [31:0] stat(input logic tr, input logic g,
      input csx_pkg::csx_state_t s);
      return {11'h000, s, tr ? `CSX_ERR_EXT : `CSX_ERR_NONE, 5'h00, g, tr, tr};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
   endtask

   // bounded wait for drive enable (sel 0) or alarm (sel 1)
   task automatic wait_on(input logic sel, input logic v);
      int n;
      n = 0;
      while ((sel ? alarm : drive_en) !== v)
      begin
         @(posedge i_mclk);
         #1;
         n++;
         if (n > 200)
         begin
            chk(32'h0, 32'h1);
            give_verdict();
         end
      end
      chk({31'h0, sel ? alarm : drive_en}, {31'h0, v});
   endtask

   // compare read answers and restarts against the oldest note
   always @(posedge i_mclk)
   begin
      rd_d <= i_rd;
      if (rd_d === 1'b1)
         chk(rdata, rd_q.pop_front());
      if (start_load === 1'b1)
      begin
         exp_f = (st_q.size() > 0) ? {16'h0, st_q.pop_front()} : 32'hffff_ffff;
         chk({16'h0, start_freq}, exp_f);
      end
   end

   task automatic round();
      c = int'(xs() & 32'h7);
      t = (c + 1 + int'(xs() % 32'd7)) % 8;
      w = 3 + int'(xs() & 32'h7);
      spd = 16'(xs()) | 16'h0001;
      fmap = '0;
      fmap[8 * c +: 8] = `CSX_OPT_COAST;
      fmap[8 * t +: 8] = `CSX_OPT_TRIP;
      wr(`CSX_ADDR_FUNC_LO, fmap[31:0]);
      wr(`CSX_ADDR_FUNC_HI, fmap[63:32]);
      wr(`CSX_ADDR_RESTART, 32'h0000_0001);
      rd(`CSX_ADDR_FUNC_LO, fmap[31:0]);
      rd(`CSX_ADDR_FUNC_HI, fmap[63:32]);
      keep_m = 8'(1 << c) | 8'(1 << t);
      i_far.set_spare(keep_m, 8'(xs()));
      i_far.set_speed(spd);
      // run from stop, then coast and resume from motor speed
      st_q.push_back(16'h0);
      i_far.set_run(1'b1);
      wait_on(1'b0, 1'b1);
      rd(`CSX_ADDR_STATUS, stat(1'b0, 1'b0, csx_pkg::CSX_ST_RUN));
      i_far.set_pin(c, 1'b1);
      wait_on(1'b0, 1'b0);
      rd(`CSX_ADDR_STATUS, stat(1'b0, 1'b0, csx_pkg::CSX_ST_COAST));
      st_q.push_back(spd);
      i_far.set_pin(c, 1'b0);
      wait_on(1'b0, 1'b1);
      // release with run gone stays stopped
      i_far.set_pin(c, 1'b1);
      wait_on(1'b0, 1'b0);
      i_far.set_run(1'b0);
      i_far.set_pin(c, 1'b0);
      repeat (6) @(posedge i_mclk);
      rd(`CSX_ADDR_STATUS, stat(1'b0, 1'b0, csx_pkg::CSX_ST_STOP));
      i_far.set_spare(keep_m, 8'(xs()));
      // zero-frequency resume after a programmed wait
      wr(`CSX_ADDR_RESTART, 32'(w) << `CSX_WAIT_LSB);
      st_q.push_back(16'h0);
      i_far.set_run(1'b1);
      wait_on(1'b0, 1'b1);
      i_far.set_pin(c, 1'b1);
      wait_on(1'b0, 1'b0);
      st_q.push_back(16'h0);
      i_far.set_pin(c, 1'b0);
      repeat (5) @(posedge i_mclk);
      chk({31'h0, drive_en}, 32'h0);
      wait_on(1'b0, 1'b1);
      // trip edge latches once and holds after release
      i_far.set_pin(t, 1'b1);
      wait_on(1'b1, 1'b1);
      chk({24'h0, error_code}, {24'h0, `CSX_ERR_EXT});
      chk({31'h0, drive_en}, 32'h0);
      repeat (4) @(posedge i_mclk);
      i_far.set_pin(t, 1'b0);
      repeat (8) @(posedge i_mclk);
      rd(`CSX_ADDR_STATUS, stat(1'b1, 1'b0, csx_pkg::CSX_ST_TRIP));
      rd(`CSX_ADDR_HISTORY, 32'h1);
      // reset terminal clears, release resumes the held run
      i_far.set_rst(1'b1);
      wait_on(1'b1, 1'b0);
      chk({24'h0, error_code}, 32'h0);
      rd(`CSX_ADDR_HISTORY, 32'h0);
      st_q.push_back(16'h0);
      i_far.set_rst(1'b0);
      wait_on(1'b0, 1'b1);
      // guard: clearing reset alone gives no restart
      wr(`CSX_ADDR_RESTART, 32'h0000_0002);
      i_far.set_pin(t, 1'b1);
      wait_on(1'b1, 1'b1);
      i_far.set_pin(t, 1'b0);
      i_far.set_rst(1'b1);
      wait_on(1'b1, 1'b0);
      i_far.set_rst(1'b0);
      repeat (8) @(posedge i_mclk);
      rd(`CSX_ADDR_STATUS, stat(1'b0, 1'b1, csx_pkg::CSX_ST_STOP));
      st_q.push_back(16'h0);
      wr(`CSX_ADDR_STATUS, 32'h0000_0001);
      wait_on(1'b0, 1'b1);
      // power cycle clears a trip back to stop
      i_far.set_pin(t, 1'b1);
      wait_on(1'b1, 1'b1);
      i_far.set_run(1'b0);
      i_far.set_pin(t, 1'b0);
      i_far.set_spare(keep_m, 8'h00);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_mclk);
      i_rst <= 1'b0;
      rd(`CSX_ADDR_STATUS, stat(1'b0, 1'b0, csx_pkg::CSX_ST_STOP));
   endtask

   // main sequence
   initial
   begin
      i_rst = 1'b1;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      rd_d = 1'b0;
      rnd = 32'd17;
      bad_count = 0;
      checks_done = 0;
      repeat (6) @(posedge i_mclk);
      i_rst <= 1'b0;
      for (int a = 0; a < 6; a++)
         rd(8'(a * 4), (a == 3) ? stat(1'b0, 1'b0, csx_pkg::CSX_ST_STOP) : 32'h0);
      wr(8'h14, 32'hffff_ffff);
      rd(8'h14, 32'h0);
      wr(`CSX_ADDR_RESTART, 32'hffff_ffff);
      rd(`CSX_ADDR_RESTART, 32'h00ff_ff03);
      for (int r = 0; r < 2; r++)
         round();
      repeat (4) @(posedge i_mclk);
      chk(32'(rd_q.size() + st_q.size()), 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
